// >>> common/tta_pkg.sv
package tta_pkg;

   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int WORD_W = ADDR_W - 2;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] IDX_STATUS1 = 8'h41;
   localparam logic [7:0] IDX_STATUS2 = 8'h42;
   localparam logic [7:0] IDX_MASK1   = 8'h74;
   localparam logic [7:0] IDX_MASK2   = 8'h75;
   localparam logic [7:0] IDX_CFG3    = 8'h78;
   localparam logic [7:0] IDX_TIMER   = 8'h79;
   localparam logic [7:0] IDX_LIMIT   = 8'h7a;
   localparam logic [7:0] IDX_CFG4    = 8'h7d;

   // Reset values
   localparam logic [7:0] RST_MASK  = 8'h00;
   localparam logic [7:0] RST_CFG   = 8'h00;
   localparam logic [7:0] RST_LIMIT = 8'h00;
   localparam logic [7:0] RST_ZERO  = 8'h00;

   // Field positions
   localparam int CFG3_ALERT_PIN10 = 0;
   localparam int CFG3_THR_EN      = 1;
   localparam int CFG3_FULL_SPEED_ON_THROTTLE       = 2;
   localparam int CFG4_SEL_LO      = 0;
   localparam int CFG4_SEL_HI      = 1;
   localparam int MASK1_THR22      = 0;
   localparam int MASK1_OOL        = 7;
   localparam int ST1_THR22        = 0;
   localparam int ST2_OVT          = 1;
   localparam int ST2_F4P          = 5;

   // Pin 14 function select
   typedef enum logic [1:0] {
      P14_TACH     = 2'b00,
      P14_THROTTLE = 2'b01,
      P14_ALERT    = 2'b10,
      P14_GPIO     = 2'b11
   } tta_pin14_t;

   // Timer resolution
   localparam int unsigned LSB_TIME_US   = 22760;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned TICK_CYCLES   = LSB_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int          PRESC_W       = 20;
   localparam logic [7:0]  TIMER_FULL    = 8'hff;
   localparam logic [7:0]  TIMER_FIRST   = 8'h01;

   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Interrupt status 2 conditions from the monitoring logic
   typedef struct packed {
      logic remote_diode_two_fault;
      logic remote_diode_one_fault;
      logic fourth_fan_fail;
      logic fan3_fail;
      logic fan2_fail;
      logic first_fan_fail;
      logic overtemp_flag;
      logic rail12_or_vid_change;
   } tta_st2_cond_t;

endpackage

// >>> src/tta_top.sv
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
// Function
// (RL1) Mask2 bits 7 and 6 block alert for diode 2 and diode 1 faults.
// (RL2) Mask2 bit 5 blocks fourth_fan_fail, throttle or general I/O alert by pin use.
// (RL3) Mask2 bits 4..2 fans 3..1, bit 1 overtemp, bit 0 rail/VID change.
// (RL4) Alert output function stays off after reset until software assigns a pin.
// (RL5) Config3 bit 0 makes pin 10 the alert output, else fan drive 2.
// (RL6) Config4 bits 1:0 pick pin 14: tach, throttle, alert, general I/O.
// (RL7) Throttle enable makes pin 22 the throttle pin, else 2.5 V input.
// (RL8) Pin 14 throttle activity ignored while throttle enable is clear.
// (RL9) Full_speed_on_throttle bit drives fans full duty while throttle input held low.
// (RL10) Full_speed_on_throttle touches only fans already running.
// (RL11) Timer runs only while throttle asserted, holds and resumes otherwise.
// (RL12) Timer saturates at full scale until cleared by a read.
// (RL13) Timer bit 0 set on first assertion after clearing.
// (RL14) Past 45.52 ms bit 1 sets; bit 0 then weighs 22.76 ms.
// (RL15) Reading the timer returns its value and clears it.
// (RL16) Read during assertion clears, sets bit 0, counts on from zero.
// (RL17) Read during assertion with limit zero sets the fourth_fan_fail/throttle flag again.
// (RL18) Host-writable 8-bit timer limit register.
// (RL19) Timer above limit sets status2 bit 5 and alerts unless masked.
// (RL20) Mask2 bit 5 or mask1 bit 0 gates the timer alert; status still sets. Mask1 bit 0 gates only if throttle enabled, pin 14 not throttle.
// (RL21) Limit zero alerts on first assertion; limit one past 45.52 ms.
// (RL22) Status bits sticky; clear only on read after the condition ended. Status2 bit 1 (overtemp) follows its condition live.
// (RL23) Alert held through an unmasked condition and until status is read. The status2 bit 1 (overtemp) alert ends with its condition, without a read.
// (RL24) Throttle inputs pass two flip-flops before use.
// (RL25) Alert is open-drain, active low, when any unmasked status bit set.
module tta_top #(
   parameter int unsigned TICK_CYC = tta_pkg::TICK_CYCLES
) (
   input  wire logic                          aclk,
   input  wire logic                          aresetn,
   input  wire logic [tta_pkg::ADDR_W-1:0]    s_axi_awaddr,
   input  wire logic [2:0]                    s_axi_awprot,
   input  wire logic                          s_axi_awvalid,
   output logic                               s_axi_awready,
   input  wire logic [tta_pkg::DATA_W-1:0]    s_axi_wdata,
   input  wire logic [3:0]                    s_axi_wstrb,
   input  wire logic                          s_axi_wvalid,
   output logic                               s_axi_wready,
   output logic [1:0]                         s_axi_bresp,
   output logic                               s_axi_bvalid,
   input  wire logic                          s_axi_bready,
   input  wire logic [tta_pkg::ADDR_W-1:0]    s_axi_araddr,
   input  wire logic [2:0]                    s_axi_arprot,
   input  wire logic                          s_axi_arvalid,
   output logic                               s_axi_arready,
   output logic [tta_pkg::DATA_W-1:0]         s_axi_rdata,
   output logic [1:0]                         s_axi_rresp,
   output logic                               s_axi_rvalid,
   input  wire logic                          s_axi_rready,
   input  wire logic                          pin22_throttle_n,
   input  wire logic                          pin14_i,
   output logic                               pin14_o,
   output logic                               pin14_oe,
   output logic                               pin10_o,
   output logic                               pin10_oe,
   input  wire logic [6:0]                    st1_cond,
   input  wire tta_pkg::tta_st2_cond_t        st2_cond,
   input  wire logic [3:0]                    fan_running,
   input  wire logic                          fan_drive_output_2,
   output logic [3:0]                         full_speed_on_throttle,
   output logic                               sense_2v5_en
);
   import tta_pkg::*;

   localparam logic [PRESC_W-1:0] TICK_LAST = PRESC_W'(TICK_CYC - 1);

   logic [7:0]         mask1_reg, mask2_reg, cfg3_reg, cfg4_reg, limit_reg;
   logic [6:0]         st1_reg;
   logic [7:0]         st2_reg;
   logic [7:0]         count_reg;
   logic [PRESC_W-1:0] presc_reg;
   logic               started_reg;
   logic [1:0]         p22_sync_reg, p14_sync_reg;
   logic               wr_acc_reg, bvalid_reg, ar_acc_reg, rvalid_reg;
   logic [1:0]         bresp_reg, rresp_reg;
   logic [DATA_W-1:0]  rdata_reg;
   logic               pin10_o_reg, pin10_oe_reg, pin14_o_reg, pin14_oe_reg;
   logic [3:0]         full_speed_on_throttle_reg;
   logic               sense_reg;

   tta_pin14_t         pin14_func;
   logic               thr_en, thr22_act, thr14_act, thr_act, tick;
   logic [7:0]         timer_val;
   logic               timer_exceed;
   logic [7:0]         st1_now, st2_now, mask2_eff, st1_upd;
   logic               alert_pend;
   logic [7:0]         wr_idx, rd_idx;
   logic               wr_hit, rd_hit, wr_en, rd_fire;
   logic               rd_clr_st1, rd_clr_st2, rd_clr_tmr;

   // Maps a word address onto a known register
   function automatic logic mapped(input logic [WORD_W-1:0] w);
      logic hit;
      hit = 1'b0;
      if (w[WORD_W-1:8] == '0) begin
         case (w[7:0])
            IDX_STATUS1, IDX_STATUS2, IDX_MASK1, IDX_MASK2,
            IDX_CFG3, IDX_TIMER, IDX_LIMIT, IDX_CFG4: hit = 1'b1;
            default: hit = 1'b0;
         endcase
      end
      return hit;
   endfunction

   // Sticky flag update; a new condition wins over the read clear
   function automatic logic [7:0] sticky(input logic [7:0] cur, input logic [7:0] cond,
                                         input logic clr);
      return clr ? cond : (cur | cond);
   endfunction

   // Input synchronisers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         p22_sync_reg <= 2'b11;
         p14_sync_reg <= 2'b11;
      end else begin
         p22_sync_reg <= {p22_sync_reg[0], pin22_throttle_n};  // [RL24]
         p14_sync_reg <= {p14_sync_reg[0], pin14_i};           // [RL24]
      end
   end

   assign thr_en     = cfg3_reg[CFG3_THR_EN];
   assign pin14_func = tta_pin14_t'(cfg4_reg[CFG4_SEL_HI:CFG4_SEL_LO]);           // [RL6]
   assign thr22_act  = thr_en & ~p22_sync_reg[1];                                 // [RL7]
   assign thr14_act  = thr_en & (pin14_func == P14_THROTTLE) & ~p14_sync_reg[1];  // [RL8]
   assign thr_act    = thr22_act | thr14_act;
   assign tick       = thr_act & (presc_reg == TICK_LAST);

   // Bit 0 marks the first assertion until two ticks make bit 1
   assign timer_val    = (count_reg == RST_ZERO && started_reg) ? TIMER_FIRST : count_reg; // [RL14]
   assign timer_exceed = timer_val > limit_reg;  // [RL21] [RL17]

   // Register bus decode
   assign wr_idx     = s_axi_awaddr[9:2];
   assign rd_idx     = s_axi_araddr[9:2];
   assign wr_hit     = (s_axi_awaddr[1:0] == 2'b00) & mapped(s_axi_awaddr[ADDR_W-1:2]);
   assign rd_hit     = (s_axi_araddr[1:0] == 2'b00) & mapped(s_axi_araddr[ADDR_W-1:2]);
   assign wr_en      = wr_acc_reg & wr_hit & s_axi_wstrb[0];
   assign rd_fire    = ar_acc_reg;
   assign rd_clr_st1 = rd_fire & rd_hit & (rd_idx == IDX_STATUS1);
   assign rd_clr_st2 = rd_fire & rd_hit & (rd_idx == IDX_STATUS2);
   assign rd_clr_tmr = rd_fire & rd_hit & (rd_idx == IDX_TIMER);

   // Write channel: address and data taken together in one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_acc_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg  <= RESP_OKAY;
      end else begin
         wr_acc_reg <= s_axi_awvalid & s_axi_wvalid & ~wr_acc_reg & ~bvalid_reg;
         if (wr_acc_reg) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   // Read channel; the register is sampled the cycle the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ar_acc_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rresp_reg  <= RESP_OKAY;
         rdata_reg  <= '0;
      end else begin
         ar_acc_reg <= s_axi_arvalid & ~ar_acc_reg & ~rvalid_reg;
         if (rd_fire) begin
            rvalid_reg <= 1'b1;
            rresp_reg  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            rdata_reg  <= '0;
            if (rd_hit) begin
               unique case (rd_idx)
                  IDX_STATUS1: rdata_reg[7:0] <= {|st2_reg, st1_reg};
                  IDX_STATUS2: rdata_reg[7:0] <= st2_reg;
                  IDX_MASK1:   rdata_reg[7:0] <= mask1_reg;
                  IDX_MASK2:   rdata_reg[7:0] <= mask2_reg;
                  IDX_CFG3:    rdata_reg[7:0] <= cfg3_reg;
                  IDX_TIMER:   rdata_reg[7:0] <= timer_val;   // [RL15]
                  IDX_LIMIT:   rdata_reg[7:0] <= limit_reg;
                  IDX_CFG4:    rdata_reg[7:0] <= cfg4_reg;
                  default:     rdata_reg[7:0] <= RST_ZERO;
               endcase
            end
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mask1_reg <= RST_MASK;
         mask2_reg <= RST_MASK;
         cfg3_reg  <= RST_CFG;   // [RL4]
         cfg4_reg  <= RST_CFG;   // [RL4]
         limit_reg <= RST_LIMIT;
      end else if (wr_en) begin
         unique case (wr_idx)
            IDX_MASK1: mask1_reg <= s_axi_wdata[7:0];
            IDX_MASK2: mask2_reg <= s_axi_wdata[7:0];
            IDX_CFG3:  cfg3_reg  <= s_axi_wdata[7:0];
            IDX_CFG4:  cfg4_reg  <= s_axi_wdata[7:0];
            IDX_LIMIT: limit_reg <= s_axi_wdata[7:0];  // [RL18]
            default:   limit_reg <= limit_reg;
         endcase
      end
   end

   // Throttle assertion timer
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         presc_reg   <= '0;
         count_reg   <= RST_ZERO;
         started_reg <= 1'b0;
      end else if (rd_clr_tmr) begin
         presc_reg   <= '0;                // [RL16]
         count_reg   <= RST_ZERO;          // [RL15]
         started_reg <= thr_act;           // [RL16]
      end else if (thr_act) begin
         started_reg <= 1'b1;              // [RL13]
         presc_reg   <= tick ? '0 : presc_reg + 1'b1;  // [RL11]
         if (tick && count_reg != TIMER_FULL) begin
            count_reg <= count_reg + 8'h01;  // [RL12]
         end
      end
   end

   // Status conditions; pin 22 throttle replaces the 2.5 V flag
   always_comb begin
      st1_now            = {1'b0, st1_cond};
      st2_now            = st2_cond;
      if (thr_en) begin
         st1_now[ST1_THR22] = thr22_act;
      end
      st2_now[ST2_F4P] = timer_exceed |
                         ((pin14_func != P14_THROTTLE) & st2_cond.fourth_fan_fail); // [RL19]
   end

   assign st1_upd = sticky({1'b0, st1_reg}, st1_now, rd_clr_st1);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st1_reg <= 7'h00;
         st2_reg <= RST_ZERO;
      end else begin
         st1_reg <= st1_upd[6:0];                                         // [RL22]
         st2_reg <= sticky(st2_reg, st2_now, rd_clr_st2);                 // [RL22]
         st2_reg[ST2_OVT] <= st2_now[ST2_OVT];
      end
   end

   // Alert gating
   always_comb begin
      mask2_eff = mask2_reg;  // [RL1] [RL3]
      mask2_eff[ST2_F4P] = mask2_reg[ST2_F4P] |  // [RL2] [RL20]
         (thr_en & (pin14_func != P14_THROTTLE) & mask1_reg[MASK1_THR22]);
      alert_pend = (|(st1_reg & ~mask1_reg[6:0])) |
                   (~mask1_reg[MASK1_OOL] & (|(st2_reg & ~mask2_eff)));      // [RL23] [RL25]
   end

   // Pin drivers and fan full_speed_on_throttle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin10_o_reg  <= 1'b0;
         pin10_oe_reg <= 1'b0;
         pin14_o_reg  <= 1'b0;
         pin14_oe_reg <= 1'b0;
         full_speed_on_throttle_reg    <= 4'h0;
         sense_reg    <= 1'b1;
      end else begin
         if (cfg3_reg[CFG3_ALERT_PIN10]) begin
            pin10_o_reg  <= 1'b0;         // [RL5]
            pin10_oe_reg <= alert_pend;   // [RL25]
         end else begin
            pin10_o_reg  <= fan_drive_output_2;
            pin10_oe_reg <= 1'b1;
         end
         pin14_o_reg  <= 1'b0;
         pin14_oe_reg <= (pin14_func == P14_ALERT) & alert_pend;  // [RL6] [RL25]
         full_speed_on_throttle_reg    <= {4{cfg3_reg[CFG3_FULL_SPEED_ON_THROTTLE] & thr_act}} & fan_running;  // [RL9] [RL10]
         sense_reg    <= ~thr_en;  // [RL7]
      end
   end

   assign s_axi_awready          = wr_acc_reg;
   assign s_axi_wready           = wr_acc_reg;
   assign s_axi_bvalid           = bvalid_reg;
   assign s_axi_bresp            = bresp_reg;
   assign s_axi_arready          = ar_acc_reg;
   assign s_axi_rvalid           = rvalid_reg;
   assign s_axi_rresp            = rresp_reg;
   assign s_axi_rdata            = rdata_reg;
   assign pin10_o                = pin10_o_reg;
   assign pin10_oe               = pin10_oe_reg;
   assign pin14_o                = pin14_o_reg;
   assign pin14_oe               = pin14_oe_reg;
   assign full_speed_on_throttle = full_speed_on_throttle_reg;
   assign sense_2v5_en           = sense_reg;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_rd_take;
      s_axi_arvalid && !ar_acc_reg && !rvalid_reg;
   endsequence
   sequence s_rd_answer;
      ar_acc_reg ##1 rvalid_reg;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid && s_axi_wvalid && !wr_acc_reg && !bvalid_reg;
   endsequence
   sequence s_wr_answer;
      wr_acc_reg ##1 bvalid_reg;
   endsequence


   a_tmr_saturate: assert property (count_reg == TIMER_FULL && !rd_clr_tmr |=> // [RL12]
      count_reg == TIMER_FULL) else $error("timer left full scale");
   a_tmr_pause: assert property (!thr_act && !rd_clr_tmr |=> // [RL11]
      $stable(count_reg) && $stable(presc_reg)) else $error("timer moved while idle");
   a_tmr_advance: assert property (tick && count_reg != TIMER_FULL && !rd_clr_tmr |=> // [RL11]
      count_reg == $past(count_reg) + 8'h01) else $error("timer missed a tick");
   a_first_bit: assert property (thr_act && !rd_clr_tmr |=> timer_val != RST_ZERO) // [RL13]
      else $error("first assertion bit not set");
   a_read_clear: assert property (rd_clr_tmr |=> count_reg == RST_ZERO && // [RL16]
      started_reg == $past(thr_act)) else $error("timer not cleared by read");
   a_read_value: assert property (rd_clr_tmr |=> s_axi_rdata[7:0] == $past(timer_val)) // [RL15]
      else $error("timer read value wrong");
   a_f4p_set: assert property (timer_exceed |=> st2_reg[ST2_F4P]) // [RL19]
      else $error("limit exceed did not set flag");
   a_sticky_hold: assert property (st2_reg[ST2_F4P] && !rd_clr_st2 |=> st2_reg[ST2_F4P]) // [RL22]
      else $error("sticky flag dropped without read");
   a_alert_pin10: assert property (cfg3_reg[CFG3_ALERT_PIN10] |=> // [RL25]
      pin10_oe == $past(alert_pend) && !pin10_o) else $error("pin 10 alert drive wrong");
   a_full_speed_on_throttle_gate: assert property (1'b1 |=> full_speed_on_throttle == // [RL10]
      ($past(fan_running) & {4{$past(cfg3_reg[CFG3_FULL_SPEED_ON_THROTTLE]) && $past(thr_act)}}))
      else $error("full_speed_on_throttle gating wrong");
   a_throttle_off: assert property (!thr_en |-> !thr_act) // [RL8]
      else $error("throttle seen while disabled");
   a_rd_handshake: assert property (s_rd_take |=> s_rd_answer)
      else $error("read not answered in two cycles");

   a_wr_handshake: assert property (s_wr_take |=> s_wr_answer)
      else $error("write not answered in two cycles");

   a_rvalid_hold: assert property (rvalid_reg && !s_axi_rready |=> rvalid_reg &&
      $stable(rdata_reg)) else $error("read answer dropped early");

   a_ovt_live: assert property (1'b1 |=> st2_reg[ST2_OVT] == $past(st2_now[ST2_OVT])) // [RL22]
      else $error("overtemp flag held");

   a_st2_read: assert property (rd_clr_st2 |=> st2_reg == $past(st2_now)) // [RL22]
      else $error("status read clear wrong");

   a_pin14_alert: assert property (1'b1 |=> !pin14_o && // [RL6]
      pin14_oe == ($past(pin14_func == P14_ALERT) && $past(alert_pend)))
      else $error("pin 14 alert drive wrong");

   a_pin10_drive: assert property (!cfg3_reg[CFG3_ALERT_PIN10] |=> pin10_oe && // [RL5]
      pin10_o == $past(fan_drive_output_2)) else $error("pin 10 drive wrong");

   a_sense_sel: assert property (1'b1 |=> sense_2v5_en == !$past(thr_en)) // [RL7]
      else $error("2.5 V input select wrong");

   a_limit_write: assert property (wr_en && wr_idx == IDX_LIMIT |=> // [RL18]
      limit_reg == $past(s_axi_wdata[7:0])) else $error("limit write lost");

   a_thr_first: assert property ($rose(thr_act) && count_reg == RST_ZERO && // [RL13]
      !rd_clr_tmr |=> timer_val == TIMER_FIRST) else $error("first mark missing");


endmodule

// >>> testbench/tta_pin_model.sv
`timescale 1ns/1ps
module tta_pin_model (
   input  wire logic pull22_low,
   input  wire logic pull14_low,
   input  wire logic pin14_o,
   input  wire logic pin14_oe,
   input  wire logic pin10_o,
   input  wire logic pin10_oe,
   output logic      pin22_level,
   output logic      pin14_level,
   output logic      pin10_level
);
   logic link_clk = 1'b0;
   logic pull14_q = 1'b0;
   // Throttle source moves on its own 200 ns lattice, unrelated in phase to aclk
   initial begin
      #3;
      forever #100 link_clk = ~link_clk;
   end
   initial pin22_level = 1'b1;
   always @(posedge link_clk) begin
      pin22_level <= ~pull22_low;
      pull14_q    <= pull14_low;
   end
   // Pin 14 has a pull-up; low when the far side or the device pulls it
   assign pin14_level = ~(pull14_q | (pin14_oe & ~pin14_o));
   assign pin10_level = pin10_oe ? pin10_o : 1'b1;
endmodule

// >>> testbench/test_thermal_throttle_pin_timer_alert_logic.sv
`timescale 1ns/1ps
module test_thermal_throttle_pin_timer_alert_logic;
   import tta_pkg::*;
   localparam int unsigned TICK = 10;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        pull22_low = 1'b0, pull14_low = 1'b0, fan_drive_output_2 = 1'b0;
   logic        pin22_level, pin14_level, pin10_level, pin14_o, pin14_oe, pin10_o, pin10_oe;
   logic [6:0]  st1_cond = '0;
   tta_st2_cond_t st2_cond = '0;
   logic [3:0]  fan_running = 4'b0101, full_speed_on_throttle;
   logic        sense_2v5_en;
   int          err_total = 0, num_checks = 0;

   always #12.5 aclk = ~aclk;

   tta_top #(.TICK_CYC(TICK)) tta_top_i (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .pin22_throttle_n(pin22_level), .pin14_i(pin14_level),
      .pin14_o(pin14_o), .pin14_oe(pin14_oe), .pin10_o(pin10_o), .pin10_oe(pin10_oe),
      .st1_cond(st1_cond), .st2_cond(st2_cond), .fan_running(fan_running),
      .fan_drive_output_2(fan_drive_output_2), .full_speed_on_throttle(full_speed_on_throttle),
      .sense_2v5_en(sense_2v5_en)
   );

   tta_pin_model tta_pin_model_i (
      .pull22_low(pull22_low), .pull14_low(pull14_low), .pin14_o(pin14_o),
      .pin14_oe(pin14_oe), .pin10_o(pin10_o), .pin10_oe(pin10_oe),
      .pin22_level(pin22_level), .pin14_level(pin14_level), .pin10_level(pin10_level)
   );

   function automatic logic [11:0] ba(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge aclk);
      #1;
   endtask

   task automatic axi_wr(input logic [11:0] a, input logic [7:0] v, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= {24'h0, v};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do @(posedge aclk); while (s_axi_awready !== 1'b1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   endtask

   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] v);
      axi_wr(ba(idx), v, RESP_OKAY);
   endtask

   task automatic chk_rd(input logic [7:0] idx, input logic [7:0] e);
      logic [31:0] d;
      logic [1:0]  r;
      axi_rd(ba(idx), d, r);
      chk({30'h0, r}, {30'h0, RESP_OKAY});
      chk(d, {24'h0, e});
   endtask

   // Holds the throttle pin low for n cycles, a multiple of the lattice, then lets it settle
   task automatic thr(input int n);
      @(posedge aclk);
      pull22_low <= 1'b1;
      repeat (n) @(posedge aclk);
      pull22_low <= 1'b0;
      repeat (20) @(posedge aclk);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge aclk);
      err_total++;
      tally_and_finish();
   end

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  bitv;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      look(2);
      chk1(pin10_oe, 1'b1);
      chk1(pin14_oe, 1'b0);
      chk1(sense_2v5_en, 1'b1);
      chk_rd(IDX_MASK2, RST_MASK);
      chk_rd(IDX_TIMER, RST_ZERO);
      chk_rd(IDX_LIMIT, RST_LIMIT);
      chk_rd(IDX_CFG3, RST_CFG);
      axi_rd(12'hffc, d, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      axi_wr(12'hffc, 8'h55, RESP_SLVERR);
      wr(IDX_LIMIT, 8'ha5);
      chk_rd(IDX_LIMIT, 8'ha5);
      wr(IDX_TIMER, 8'h33);
      chk_rd(IDX_TIMER, 8'h00);
      @(posedge aclk) fan_drive_output_2 <= 1'b1;
      look(3);
      chk1(pin10_level, 1'b1);
      @(posedge aclk) fan_drive_output_2 <= 1'b0;
      look(3);
      chk1(pin10_level, 1'b0);
      wr(IDX_CFG3, 8'h01);
      wr(IDX_CFG4, 8'h02);
      look(3);
      chk1(pin10_level, 1'b1);
      // Each status2 source: masked sets status only, unmasked pulls both alert pins
      for (int i = 0; i < 8; i++) begin
         bitv = 8'h01 << i;
         wr(IDX_MASK2, bitv);
         @(posedge aclk) st2_cond <= tta_st2_cond_t'(bitv);
         look(4);
         chk1(pin10_level, 1'b1);
         chk_rd(IDX_STATUS2, bitv);
         wr(IDX_MASK2, 8'h00);
         look(3);
         chk1(pin10_level, 1'b0);
         chk1(pin14_level, 1'b0);
         @(posedge aclk) st2_cond <= '0;
         look(3);
         chk1(pin10_level, (i == 1) ? 1'b1 : 1'b0);
         chk_rd(IDX_STATUS2, (i == 1) ? 8'h00 : bitv);
         look(3);
         chk1(pin10_level, 1'b1);
      end
      @(posedge aclk) st2_cond <= tta_st2_cond_t'(8'h80);
      for (int m = 0; m < 4; m++) begin
         wr(IDX_CFG4, 8'(m ^ 2));
         look(3);
         chk1(pin14_oe, (m == 0) ? 1'b1 : 1'b0);
      end
      @(posedge aclk) st2_cond <= '0;
      chk_rd(IDX_STATUS2, 8'h80);
      // Pin 14 chosen as throttle while throttle is disabled
      wr(IDX_CFG4, 8'h01);
      @(posedge aclk) pull14_low <= 1'b1;
      repeat (48) @(posedge aclk);
      pull14_low <= 1'b0;
      look(20);
      chk_rd(IDX_TIMER, 8'h00);
      wr(IDX_CFG4, 8'h00);
      wr(IDX_LIMIT, 8'h00);
      wr(IDX_CFG3, 8'h07);
      look(3);
      chk1(sense_2v5_en, 1'b0);
      thr(8);
      chk1(pin10_level, 1'b0);
      chk_rd(IDX_TIMER, TIMER_FIRST);
      chk_rd(IDX_STATUS2, 8'h20);
      chk_rd(IDX_STATUS1, 8'h01);
      look(3);
      chk1(pin10_level, 1'b1);
      @(posedge aclk) pull22_low <= 1'b1;
      look(24);
      chk({28'h0, full_speed_on_throttle}, {28'h0, fan_running});
      repeat (16) @(posedge aclk);
      pull22_low <= 1'b0;
      look(20);
      chk({28'h0, full_speed_on_throttle}, 32'h0);
      chk_rd(IDX_TIMER, 8'h04);
      thr(32);
      thr(32);
      chk_rd(IDX_TIMER, 8'h06);
      chk_rd(IDX_TIMER, 8'h00);
      chk_rd(IDX_STATUS2, 8'h20);
      wr(IDX_LIMIT, 8'h03);
      thr(32);
      chk_rd(IDX_STATUS2, 8'h00);
      thr(16);
      chk_rd(IDX_STATUS1, 8'h81);
      look(3);
      chk1(pin10_level, 1'b0);
      wr(IDX_MASK1, 8'h01);
      look(3);
      chk1(pin10_level, 1'b1);
      chk_rd(IDX_STATUS2, 8'h20);
      wr(IDX_MASK1, 8'h00);
      chk_rd(IDX_TIMER, 8'h04);
      chk_rd(IDX_STATUS2, 8'h20);
      wr(IDX_LIMIT, 8'h00);
      @(posedge aclk) pull22_low <= 1'b1;
      repeat (2600) @(posedge aclk);
      chk_rd(IDX_TIMER, TIMER_FULL);
      chk_rd(IDX_TIMER, TIMER_FIRST);
      chk_rd(IDX_STATUS2, 8'h20);
      @(posedge aclk) pull22_low <= 1'b0;
      look(20);
      tally_and_finish();
   end
endmodule
